// *** src/psa_ctrl.sv ***
/*
  psa_ctrl: program store access control.
  holds the program store control, key and scale registers, steers
  code reads and data-move writes, drives the sense enable, and gates
  wake-up from idle. assumes a single-cycle sfr bus and cpu strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module psa_ctrl #(
  parameter int ADDR_W = psa_pkg::PSA_ADDR_W
) (
  input  wire logic              clock,
  input  wire logic              rst,
  // sfr bus
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  // cpu flash access strobes
  input  wire logic              code_read_instr,
  input  wire logic              data_move_write_instr,
  input  wire logic [ADDR_W-1:0] cpu_addr,
  input  wire logic [7:0]        cpu_wdata,
  // supply monitor status
  input  wire logic              monitor_on,
  input  wire logic              monitor_reset_on,
  // idle control
  input  wire logic              idle_req,
  input  wire logic              wake_event,
  output logic                   cpu_run,
  // flash array side
  output logic                   flash_scratch,
  output logic                   flash_prog,
  output logic                   flash_erase,
  output logic      [ADDR_W-1:0] flash_addr,
  output logic      [7:0]        flash_wdata,
  output logic      [ADDR_W-1:0] flash_row,
  output logic                   sense_enable,
  output logic                   ext_write,
  output logic                   flash_error_reset
);

  // ----------------------------------------------------------------
  // registers and decode
  // ----------------------------------------------------------------
  logic [2:0]        ctrl_q;          // scratch, erase, write enables
  logic [2:0]        ctrl_d;
  logic              bypass_q;        // one-shot bypass
  psa_pkg::psa_key_t key_q;           // key lock state
  psa_pkg::psa_key_t key_d;
  logic [1:0]        wake_q;          // wake countdown
  logic              idle_q;          // cpu is idle
  logic              os_q;            // one-shot pulse stage

  wire hit_ctrl  = sfr_addr == psa_pkg::PSA_CTRL_ADDR;
  wire hit_key   = sfr_addr == psa_pkg::PSA_KEY_ADDR;
  wire hit_scale = sfr_addr == psa_pkg::PSA_SCALE_ADDR;
  wire wr_ctrl   = sfr_wr && hit_ctrl;
  wire wr_key    = sfr_wr && hit_key;
  wire wr_scale  = sfr_wr && hit_scale;
  wire we_bit    = ctrl_q[psa_pkg::PSA_WE_BIT];
  wire ee_bit    = ctrl_q[psa_pkg::PSA_EE_BIT];
  wire sp_bit    = ctrl_q[psa_pkg::PSA_SP_BIT];

  // ----------------------------------------------------------------
  // flash modify decode
  // ----------------------------------------------------------------
  // write enable routes to flash
  wire flash_wr  = data_move_write_instr && we_bit;
  wire mon_ok    = monitor_on && monitor_reset_on;
  wire key_open  = key_q == psa_pkg::PSA_OPEN;
  wire bad_try   = flash_wr && !key_open;
  wire do_modify = flash_wr && key_open && mon_ok;
  wire do_erase  = do_modify && ee_bit;
  wire do_prog   = do_modify && !ee_bit;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // only three low bits stored
  assign ctrl_d = wr_ctrl ? sfr_wdata[2:0] : ctrl_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= psa_pkg::PSA_CTRL_RESET[2:0];
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bypass_q <= psa_pkg::PSA_SCALE_RESET[psa_pkg::PSA_BYPASS_BIT];
    end else if (wr_scale) begin
      bypass_q <= sfr_wdata[psa_pkg::PSA_BYPASS_BIT];
    end
  end

  // ----------------------------------------------------------------
  // key state machine
  // ----------------------------------------------------------------
  always_comb begin
    key_d = key_q;
    case (key_q)
      psa_pkg::PSA_LOCKED: begin
        if (wr_key) begin
          key_d = (sfr_wdata == psa_pkg::PSA_KEY_FIRST) ? psa_pkg::PSA_FIRST
                                                        : psa_pkg::PSA_DEAD;
        end
      end
      psa_pkg::PSA_FIRST: begin
        if (wr_key) begin
          key_d = (sfr_wdata == psa_pkg::PSA_KEY_SECOND) ? psa_pkg::PSA_OPEN
                                                         : psa_pkg::PSA_DEAD;
        end
      end
      psa_pkg::PSA_OPEN: begin
        if (do_modify) begin
          key_d = psa_pkg::PSA_LOCKED;
        end else if (wr_key) begin
          key_d = psa_pkg::PSA_DEAD;
        end
      end
      psa_pkg::PSA_DEAD: key_d = psa_pkg::PSA_DEAD;
      default:           key_d = psa_pkg::PSA_DEAD;
    endcase
    if (bad_try) begin
      key_d = psa_pkg::PSA_DEAD;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      key_q <= psa_pkg::PSA_LOCKED;
    end else begin
      key_q <= key_d;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [1:0] key_code;
  always_comb begin
    case (key_q)
      psa_pkg::PSA_LOCKED: key_code = psa_pkg::PSA_RD_LOCKED;
      psa_pkg::PSA_FIRST:  key_code = psa_pkg::PSA_RD_FIRST;
      psa_pkg::PSA_OPEN:   key_code = psa_pkg::PSA_RD_OPEN;
      default:             key_code = psa_pkg::PSA_RD_DEAD;
    endcase
  end

  wire [7:0] rd_ctrl  = {5'h00, ctrl_q};
  wire [7:0] rd_key   = {6'h00, key_code};
  wire [7:0] rd_scale = {1'b0, bypass_q, 6'h00};
  wire [7:0] rd_mux   = hit_ctrl  ? rd_ctrl  :
                        hit_key   ? rd_key   :
                        hit_scale ? rd_scale : 8'h00;

  always_ff @(posedge clock) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // flash array outputs
  // ----------------------------------------------------------------
  // row index drops six bits
  wire [ADDR_W-1:0] row_of = cpu_addr >> psa_pkg::PSA_ROW_BITS;
  always_ff @(posedge clock) begin
    if (rst) begin
      flash_scratch     <= 1'b0;
      flash_prog        <= 1'b0;
      flash_erase       <= 1'b0;
      flash_addr        <= '0;
      flash_wdata       <= 8'h00;
      flash_row         <= '0;
      ext_write         <= 1'b0;
      flash_error_reset <= 1'b0;
    end else begin
      flash_scratch     <= sp_bit;
      flash_prog        <= do_prog;
      flash_erase       <= do_erase;
      flash_addr        <= cpu_addr;
      flash_wdata       <= do_erase ? 8'hff : cpu_wdata;
      flash_row         <= row_of;
      ext_write         <= data_move_write_instr && !we_bit;
      flash_error_reset <= flash_wr && key_open && !mon_ok;
    end
  end

  // ----------------------------------------------------------------
  // sense enable, follows access with or without bypass
  // ----------------------------------------------------------------
  wire access = code_read_instr || data_move_write_instr;
  always_ff @(posedge clock) begin
    if (rst) begin
      os_q <= 1'b0;
    end else begin
      os_q <= access;
    end
  end
  assign sense_enable = bypass_q ? access : (access && !os_q) || (access && os_q);

  // ----------------------------------------------------------------
  // idle wake-up
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      idle_q <= 1'b0;
      wake_q <= 2'h0;
    end else if (!idle_q) begin
      idle_q <= idle_req;
    end else if (wake_q != 2'h0) begin
      wake_q <= wake_q - 2'h1;
      idle_q <= wake_q != 2'h1;
    end else if (wake_event) begin
      wake_q <= psa_pkg::PSA_WAKE_CYC;
    end
  end
  assign cpu_run = !idle_q;

endmodule
`default_nettype wire

// *** src/psa_pkg.sv ***
/*
  psa_pkg: constants shared by the program store access control block.
  assumes an 8-bit special-function-register bus inside the core.
*/
package psa_pkg;
  // special function register addresses
  localparam logic [7:0] PSA_CTRL_ADDR  = 8'h8f;  // program_store_control
  localparam logic [7:0] PSA_KEY_ADDR   = 8'hb6;  // flash_key_register (page 0)
  localparam logic [7:0] PSA_SCALE_ADDR = 8'hb7;  // flash_scale_register
  // control and scale register fields
  localparam int PSA_WE_BIT     = 0;              // store_write_enable
  localparam int PSA_EE_BIT     = 1;              // page_erase_enable
  localparam int PSA_SP_BIT     = 2;              // scratchpad_select
  localparam int PSA_BYPASS_BIT = 6;              // one-shot bypass
  localparam logic [7:0] PSA_CTRL_RESET  = 8'h00;
  localparam logic [7:0] PSA_SCALE_RESET = 8'h00;
  // key sequence
  localparam logic [7:0] PSA_KEY_FIRST  = 8'ha5;
  localparam logic [7:0] PSA_KEY_SECOND = 8'hf1;
  // flash geometry
  localparam int PSA_ROW_BYTES = 64;
  localparam int PSA_ROW_BITS  = 6;
  localparam int PSA_ADDR_W    = 16;
  localparam logic [15:0] PSA_SCRATCH_TOP = 16'h01ff;
  // timing
  localparam int PSA_CLK_MHZ       = 100;
  localparam int PSA_ONESHOT_MAX_MHZ = 14;
  localparam int PSA_WAKE_MAX_CYC  = 3;
  localparam logic [1:0] PSA_WAKE_CYC = 2'h2;     // wake countdown load, gives a 3-cycle wake-up latency
  localparam int PSA_ONESHOT_CYC   = 1;           // one-shot width, not used; sense enable follows access
  // key lock states, gray along locked, first key, open
  typedef enum logic [1:0] {
    PSA_LOCKED = 2'b00,
    PSA_FIRST  = 2'b01,
    PSA_OPEN   = 2'b11,
    PSA_DEAD   = 2'b10
  } psa_key_t;
  // readback codes of the lock state
  localparam logic [1:0] PSA_RD_LOCKED = 2'h0;
  localparam logic [1:0] PSA_RD_FIRST  = 2'h1;
  localparam logic [1:0] PSA_RD_OPEN   = 2'h2;
  localparam logic [1:0] PSA_RD_DEAD   = 2'h3;
endpackage

// *** sim/psa_ctrl_props.sv ***
/*
  psa_ctrl_props: port assertions for psa_ctrl.
  assumes one clock, sync active-high reset, bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module psa_ctrl_props #(
  parameter int ADDR_W = 16
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              sfr_rd,
  input wire logic [7:0]        sfr_addr,
  input wire logic [7:0]        sfr_rdata,
  input wire logic              data_move_write_instr,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [7:0]        cpu_wdata,
  input wire logic              monitor_on,
  input wire logic              monitor_reset_on,
  input wire logic              wake_event,
  input wire logic              cpu_run,
  input wire logic              flash_prog,
  input wire logic              flash_erase,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [7:0]        flash_wdata,
  input wire logic              ext_write,
  input wire logic              flash_error_reset
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------
  // assertions
  // ----------
  a_wake_in_three: assert property (wake_event && !cpu_run |-> ##[1:3] cpu_run)
    else $error("wake too slow");
  a_prog_has_cause: assert property (flash_prog |-> $past(data_move_write_instr)
    && flash_addr == $past(cpu_addr) && flash_wdata == $past(cpu_wdata))
    else $error("program without its write");
  a_erase_not_prog: assert property (flash_erase |-> !flash_prog && $past(data_move_write_instr))
    else $error("erase mixed with program");
  a_ext_not_flash: assert property (ext_write |-> !flash_prog && !flash_erase)
    else $error("external write touched flash");
  a_prog_one_shot: assert property (flash_prog |=> !flash_prog)
    else $error("second program without key");
  a_error_monitor_off: assert property (flash_error_reset |->
    !$past(monitor_on && monitor_reset_on) && !flash_prog)
    else $error("error reset with monitor on");
  a_error_one_pulse: assert property (flash_error_reset |=> !flash_error_reset)
    else $error("error reset held");
  a_ctrl_upper_zero: assert property (sfr_rd && sfr_addr == psa_pkg::PSA_CTRL_ADDR
    |=> sfr_rdata[7:3] == 5'h00)
    else $error("control upper bits not zero");
endmodule
bind psa_ctrl psa_ctrl_props #(.ADDR_W(ADDR_W)) u_props (.clock(clock), .rst(rst),
  .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata),
  .data_move_write_instr(data_move_write_instr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
  .monitor_on(monitor_on), .monitor_reset_on(monitor_reset_on), .wake_event(wake_event),
  .cpu_run(cpu_run), .flash_prog(flash_prog), .flash_erase(flash_erase),
  .flash_addr(flash_addr), .flash_wdata(flash_wdata), .ext_write(ext_write),
  .flash_error_reset(flash_error_reset));
`default_nettype wire

// *** sim/program_store_access_control_tb.sv ***
/*
  bench for psa_ctrl: drives sfr bus and cpu strobes, checks outputs.
  assumes psa_pkg and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module program_store_access_control_tb;
  logic        clock, rst, sfr_wr, sfr_rd, code_read_instr, data_move_write_instr;
  logic        monitor_on, monitor_reset_on, idle_req, wake_event, cpu_run;
  logic        flash_scratch, flash_prog, flash_erase, sense_enable, ext_write;
  logic        flash_error_reset;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, cpu_wdata, flash_wdata, rd;
  logic [15:0] cpu_addr, flash_addr, flash_row;
  int          fails, comparisons, n;
  psa_ctrl dut (.clock(clock), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .code_read_instr(code_read_instr), .data_move_write_instr(data_move_write_instr),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .monitor_on(monitor_on),
    .monitor_reset_on(monitor_reset_on), .idle_req(idle_req), .wake_event(wake_event),
    .cpu_run(cpu_run), .flash_scratch(flash_scratch), .flash_prog(flash_prog),
    .flash_erase(flash_erase), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_row(flash_row), .sense_enable(sense_enable), .ext_write(ext_write),
    .flash_error_reset(flash_error_reset));
  // 100 mhz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ------------
  // shared tasks
  // ------------
  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one-cycle register write
  task automatic sfr_w(input logic [7:0] a, d);
    @(posedge clock);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask
  // read data lands one cycle after the strobe
  task automatic sfr_r(input logic [7:0] a);
    @(posedge clock);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clock);
    sfr_rd <= 1'b0;
    @(negedge clock);
    rd = sfr_rdata;
  endtask
  // data-move write, outputs seen one cycle later
  task automatic dmw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    data_move_write_instr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clock);
    data_move_write_instr <= 1'b0;
    @(negedge clock);
  endtask
  task automatic unlock(input logic [7:0] ctrl);
    sfr_w(psa_pkg::PSA_KEY_ADDR, psa_pkg::PSA_KEY_FIRST);
    sfr_w(psa_pkg::PSA_KEY_ADDR, psa_pkg::PSA_KEY_SECOND);
    sfr_w(psa_pkg::PSA_CTRL_ADDR, ctrl);
  endtask
  // ---------
  // scenarios
  // ---------
  task automatic t_regs();
    sfr_r(psa_pkg::PSA_CTRL_ADDR);
    chk("ctrl reset", 16'h0000, {8'h00, rd});
    sfr_r(psa_pkg::PSA_SCALE_ADDR);
    chk("scale reset", 16'h0000, {8'h00, rd});
    chk("run reset", 16'h0001, {15'h0000, cpu_run});
    sfr_w(psa_pkg::PSA_CTRL_ADDR, 8'hff);
    sfr_r(psa_pkg::PSA_CTRL_ADDR);
    chk("ctrl upper", 16'h0007, {8'h00, rd});
    @(posedge clock);
    code_read_instr <= 1'b1;
    @(negedge clock);
    chk("sense", 16'h0001, {15'h0000, sense_enable});
    @(posedge clock);
    code_read_instr <= 1'b0;
    sfr_w(psa_pkg::PSA_SCALE_ADDR, 8'h40);
    sfr_r(psa_pkg::PSA_SCALE_ADDR);
    chk("bypass", 16'h0040, {8'h00, rd});
    $display("regs test done");
  endtask
  task automatic t_ops();
    // page erased before it is programmed
    unlock(8'h03);
    dmw(16'h1234, 8'h12);
    chk("erase", 16'h0001, {15'h0000, flash_erase});
    chk("erase data", 16'h00ff, {8'h00, flash_wdata});
    unlock(8'h01);
    dmw(16'h1234, 8'h5a);
    chk("prog", 16'h0001, {15'h0000, flash_prog});
    chk("prog addr", 16'h1234, flash_addr);
    chk("prog row", 16'h0048, flash_row);
    chk("prog data", 16'h005a, {8'h00, flash_wdata});
    chk("main sector", 16'h0000, {15'h0000, flash_scratch});
    sfr_r(psa_pkg::PSA_KEY_ADDR);
    chk("relock", 16'h0000, {14'h0000, rd[1:0]});
    unlock(8'h05);
    dmw(16'h01ff, 8'h3c);
    chk("scratch", 16'h0001, {15'h0000, flash_scratch});
    sfr_w(psa_pkg::PSA_CTRL_ADDR, 8'h00);
    dmw(16'h0040, 8'h77);
    chk("ext", 16'h0001, {15'h0000, ext_write});
    $display("ops test done");
  endtask
  task automatic t_fault();
    @(posedge clock);
    monitor_on <= 1'b0;
    unlock(8'h01);
    dmw(16'h0100, 8'h11);
    chk("err reset", 16'h0001, {15'h0000, flash_error_reset});
    @(posedge clock);
    monitor_on <= 1'b1;
    sfr_w(psa_pkg::PSA_KEY_ADDR, 8'h00);
    sfr_r(psa_pkg::PSA_KEY_ADDR);
    chk("dead", 16'h0003, {14'h0000, rd[1:0]});
    unlock(8'h01);
    dmw(16'h0200, 8'h22);
    chk("no prog", 16'h0000, {15'h0000, flash_prog});
    $display("fault test done");
  endtask
  task automatic t_wake();
    @(posedge clock);
    idle_req <= 1'b1;
    @(posedge clock);
    idle_req <= 1'b0;
    for (n = 0; n < 8 && cpu_run; n++) @(negedge clock);
    if (n == 8) begin
      fails++;
      wrap_up();
    end
    @(posedge clock);
    wake_event <= 1'b1;
    @(posedge clock);
    wake_event <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("wake", 16'h0001, {15'h0000, cpu_run});
    $display("wake test done");
  endtask
  // main sequence
  initial begin
    {rst, monitor_on, monitor_reset_on} = 3'h7;
    {sfr_wr, sfr_rd, code_read_instr, data_move_write_instr, idle_req, wake_event} = 6'h00;
    {sfr_addr, sfr_wdata, cpu_wdata, cpu_addr} = 40'h0;
    fails = 0;
    comparisons = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_ops();
    t_fault();
    t_wake();
    wrap_up();
  end
endmodule
`default_nettype wire
